/* rtl/radio_packet_handler.sv */
/*
  packet handler: payload fifo, transmit framer and receive deframer.
  assumes host strobes on CLK_IN; link clock and rx data are async pins.
*/
// Function
// - fixed or variable format, fifo 16..64 bytes
// - fixed length from length setting, at least one
// - variable length from first byte, at least two
// - send preamble, sync, payload, optional checksum
// - start on first byte or on threshold
// - standby-filled fifo checked on entering transmit
// - flag done, stay in transmit mode
// - filler preamble bytes, finish byte before start
// - strip preamble, sync, checksum; store payload only
// - payload ready event; crc good if enabled
// - failed checksum clears fifo unless autoclear off
// - hold after packet until fifo empty
// - bit sync and sync search always on
// - sync match starts payload and raises sync
// - filter 01 accepts node address only
// - filter 10 also accepts 0x00
// - filter 11 also accepts 0x00 and 0xFF
// - address byte kept, filtering receive only
// - length byte below maximum, kept in fifo
// - compare checksum, report status and event
// - ccitt checksum catching leading, trailing zeros
// - manchester chips on payload and checksum only
// - 9-bit whitening on payload and checksum
`timescale 1ns/10ps
module radio_packet_handler #(
  parameter int DEPTH = 64
) (
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire radio_packet_pkg::mode_t MODE_IN,
  input wire radio_packet_pkg::framer_settings_t FRAMER_SETTINGS_IN,
  input wire radio_packet_pkg::event_settings_t EVENT_SETTINGS_IN,
  input wire radio_packet_pkg::receiver_settings_t RECEIVER_SETTINGS_IN,
  input wire logic [31:0] SYNC_PATTERN_VALUE_IN,
  input wire logic FIFO_WR_IN,
  input wire logic [7:0] FIFO_WDATA_IN,
  input wire logic FIFO_RD_IN,
  output logic [7:0] FIFO_RDATA_OUT,
  output logic FIFO_EMPTY_OUT,
  output logic FIFO_FULL_OUT,
  output logic [6:0] FIFO_LEVEL_OUT,
  input wire logic LINK_CLK_IN,
  input wire logic RX_DATA_IN,
  output logic TX_DATA_OUT,
  output logic TX_DONE_OUT,
  output logic SYNC_OUT,
  output logic PAYLOAD_READY_OUT,
  output logic CRC_OK_OUT,
  output logic CRC_STATUS_OUT
);
  import radio_packet_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < FIFO_STEP || DEPTH > FIFO_DEPTH_DEF || DEPTH % FIFO_STEP != 0) begin : g_depth_check
    $error("DEPTH must be 16, 32, 48 or 64");
  end

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic logic [CW-1:0] fifo_cap(input logic [1:0] sel);
    logic [7:0] c;
    c = 8'(({6'h00, sel} + 8'h01) * 8'(FIFO_STEP));
    if (c > 8'(DEPTH)) c = 8'(DEPTH);
    return CW'(c);
  endfunction

  function automatic logic [7:0] sync_byte(input logic [31:0] pat, input logic [1:0] k);
    logic [31:0] t;
    t = pat << {k, 3'b000};
    return t[31:24];
  endfunction

  function automatic logic sync_hit(input logic [31:0] sr, input logic [31:0] pat, input receiver_settings_t rs);
    logic [31:0] diff;
    logic [5:0] errs;
    diff = (sr ^ (pat >> {2'h3 - rs.sync_size, 3'b000})) & (32'hFFFF_FFFF >> {2'h3 - rs.sync_size, 3'b000});
    errs = 6'h00;
    for (int i = 0; i < 32; i++) begin
      errs = errs + {5'h00, diff[i]};
    end
    return errs <= {4'h0, rs.sync_tolerance};
  endfunction

  function automatic logic addr_ok(input logic [7:0] a, input framer_settings_t fs);
    unique case (fs.address_filter)
      FILT_NODE: return a == fs.node_address;
      FILT_NODE_LOW: return a == fs.node_address || a == ADDR_BCAST_LOW;
      FILT_NODE_BOTH: return a == fs.node_address || a == ADDR_BCAST_LOW || a == ADDR_BCAST_HIGH;
      default: return 1'b1;
    endcase
  endfunction

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  framer_settings_t fs;
  logic lclk_m_q, lclk_s_q, lclk_d_q, rxd_m_q, rxd_s_q, link_rise, link_fall;
  logic [7:0] mem_q [DEPTH], mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] count_q, count_d, cap;
  logic [7:0] rdata_q, rdata_d, head;
  logic fifo_empty, fifo_full, host_wr, host_rd, push, pop, start_cond;
  tx_state_t tx_st_q, tx_st_d;
  logic [7:0] tx_sh_q, tx_sh_d, tx_rem_q, tx_rem_d;
  logic [3:0] tx_bit_q, tx_bit_d;
  logic [1:0] tx_cnt_q, tx_cnt_d;
  logic tx_half_q, tx_half_d, tx_out_q, tx_out_d, tx_done_q, tx_done_d;
  logic tx_pop, tx_init, tx_crc_step, tx_white_step, tx_sec, tx_wb, tx_adv;
  logic [15:0] tx_crc_now, crc_val;
  rx_state_t rx_st_q, rx_st_d;
  logic [31:0] rx_sr_q, rx_sr_d;
  logic [15:0] rx_sh_q, rx_sh_d;
  logic [7:0] rx_rem_q, rx_rem_d, rx_byte, rx_rem_new;
  logic [3:0] rx_bit_q, rx_bit_d;
  logic [1:0] rx_idx_q, rx_idx_d;
  logic rx_half_q, rx_half_d, ready_q, ready_d, crc_ok_q, crc_ok_d, status_q, status_d, sync_q, sync_d;
  logic rx_push, rx_flush, rx_init, rx_crc_step, rx_white_step, rx_sec, rx_db, rx_take, rx_fin, rx_match;
  logic rx_is_len, rx_is_adr, rx_reject, white_bit;

  assign fs = FRAMER_SETTINGS_IN;

  // ------------------------------------------------------------
  // pin synchronisers and link clock edges
  // ------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      lclk_m_q <= 1'b0;
      lclk_s_q <= 1'b0;
      lclk_d_q <= 1'b0;
      rxd_m_q <= 1'b0;
      rxd_s_q <= 1'b0;
    end else begin
      lclk_m_q <= LINK_CLK_IN;
      lclk_s_q <= lclk_m_q;
      lclk_d_q <= lclk_s_q;
      rxd_m_q <= RX_DATA_IN;
      rxd_s_q <= rxd_m_q;
    end
  end

  // tx changes on the falling edge so the modem samples a settled bit
  assign link_rise = lclk_s_q & ~lclk_d_q;
  assign link_fall = ~lclk_s_q & lclk_d_q;

  // ------------------------------------------------------------
  // payload fifo
  // ------------------------------------------------------------
  assign cap = fifo_cap(fs.fifo_size);
  assign fifo_empty = count_q == '0;
  assign fifo_full = count_q >= cap;
  assign head = mem_q[rd_q];
  assign host_wr = FIFO_WR_IN && (MODE_IN == MODE_TX || (MODE_IN == MODE_STBY && fs.fifo_standby_access));
  assign host_rd = FIFO_RD_IN && !fifo_empty && (MODE_IN == MODE_RX || (MODE_IN == MODE_STBY && fs.fifo_standby_access));
  assign push = (host_wr || rx_push) && !fifo_full;
  assign pop = host_rd || (tx_pop && !fifo_empty);
  // level test: standby-filled data is seen as transmit mode is entered
  assign start_cond = EVENT_SETTINGS_IN.tx_start_on_first ? !fifo_empty
                      : count_q >= CW'(fs.fifo_threshold);

  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    count_d = count_q;
    rdata_d = host_rd ? head : rdata_q;
    if (rx_flush) begin
      wr_d = '0;
      rd_d = '0;
      count_d = '0;
    end else begin
      if (push) begin
        mem_d[wr_q] = host_wr ? FIFO_WDATA_IN : rx_byte;
        wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      count_d = count_q + CW'(push) - CW'(pop);
    end
  end

  // ------------------------------------------------------------
  // transmit framer
  // ------------------------------------------------------------
  always_comb begin
    tx_st_d = tx_st_q;
    tx_sh_d = tx_sh_q;
    tx_bit_d = tx_bit_q;
    tx_cnt_d = tx_cnt_q;
    tx_rem_d = tx_rem_q;
    tx_half_d = tx_half_q;
    tx_out_d = tx_out_q;
    tx_done_d = tx_done_q;
    tx_pop = 1'b0;
    tx_init = 1'b0;
    tx_crc_step = 1'b0;
    tx_white_step = 1'b0;
    tx_adv = 1'b0;
    tx_sec = tx_st_q == TX_PAY || tx_st_q == TX_CRC;
    tx_wb = tx_sh_q[7] ^ (fs.whitening_on & tx_sec & white_bit);
    if (MODE_IN != MODE_TX) begin
      tx_st_d = TX_FILL;
      tx_sh_d = PREAMBLE_BYTE;
      tx_bit_d = '0;
      tx_half_d = 1'b0;
      tx_out_d = 1'b0;
      tx_done_d = 1'b0;
    end else if (link_fall) begin
      if (fs.manchester_on && tx_sec && tx_half_q) begin
        tx_out_d = ~tx_out_q;
        tx_half_d = 1'b0;
        tx_adv = 1'b1;
      end else begin
        tx_out_d = tx_wb;
        tx_crc_step = tx_st_q == TX_PAY;
        tx_white_step = tx_sec;
        tx_half_d = fs.manchester_on && tx_sec;
        tx_adv = !(fs.manchester_on && tx_sec);
      end
    end
    tx_crc_now = tx_crc_step ? crc_next(crc_val, tx_sh_q[7]) : crc_val;
    if (tx_adv) begin
      tx_sh_d = {tx_sh_q[6:0], 1'b0};
      tx_bit_d = tx_bit_q + 1'b1;
      if (tx_bit_q == BYTE_LAST) begin
        tx_bit_d = '0;
        tx_sh_d = PREAMBLE_BYTE; // filler keeps running between packets
        unique case (tx_st_q)
          TX_FILL: if (start_cond) begin // switch only at a byte boundary
            tx_st_d = TX_PRE;
            tx_cnt_d = '0;
            tx_done_d = 1'b0;
          end
          TX_PRE: if (tx_cnt_q == fs.preamble_size) begin
            tx_st_d = TX_SYNC;
            tx_cnt_d = '0;
            tx_sh_d = sync_byte(SYNC_PATTERN_VALUE_IN, 2'h0);
          end else begin
            tx_cnt_d = tx_cnt_q + 1'b1;
          end
          TX_SYNC: if (tx_cnt_q == RECEIVER_SETTINGS_IN.sync_size) begin
            tx_st_d = TX_PAY;
            tx_init = 1'b1;
            tx_pop = 1'b1; // fifo holds payload only
            tx_sh_d = fifo_empty ? BYTE_RST : head;
            tx_rem_d = fs.pkt_variable ? head : fs.payload_length - 8'h01;
          end else begin
            tx_cnt_d = tx_cnt_q + 1'b1;
            tx_sh_d = sync_byte(SYNC_PATTERN_VALUE_IN, tx_cnt_q + 2'h1);
          end
          TX_PAY: if (tx_rem_q != BYTE_RST) begin
            tx_pop = 1'b1;
            tx_sh_d = fifo_empty ? BYTE_RST : head;
            tx_rem_d = tx_rem_q - 8'h01;
          end else if (fs.crc_on) begin
            tx_st_d = TX_CRC;
            tx_cnt_d = '0;
            tx_sh_d = ~tx_crc_now[15:8]; // inverted checksum exposes trailing zeros
          end else begin
            tx_st_d = TX_FILL;
            tx_done_d = 1'b1;
          end
          TX_CRC: if (tx_cnt_q == '0) begin
            tx_cnt_d = 2'h1;
            tx_sh_d = ~crc_val[7:0];
          end else begin
            tx_st_d = TX_FILL;
            tx_done_d = 1'b1; // stays in transmit until the host changes mode
          end
          default: tx_st_d = TX_FILL;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // receive deframer
  // ------------------------------------------------------------
  always_comb begin
    rx_st_d = rx_st_q;
    rx_sr_d = rx_sr_q;
    rx_sh_d = rx_sh_q;
    rx_rem_d = rx_rem_q;
    rx_bit_d = rx_bit_q;
    rx_idx_d = rx_idx_q;
    rx_half_d = rx_half_q;
    ready_d = ready_q;
    crc_ok_d = crc_ok_q;
    status_d = status_q;
    sync_d = 1'b0;
    rx_push = 1'b0;
    rx_flush = 1'b0;
    rx_init = 1'b0;
    rx_crc_step = 1'b0;
    rx_white_step = 1'b0;
    rx_take = 1'b0;
    rx_fin = 1'b0;
    rx_sec = rx_st_q == RX_PAY || rx_st_q == RX_CRC;
    rx_db = rxd_s_q ^ (fs.whitening_on & rx_sec & white_bit);
    rx_byte = {rx_sh_q[6:0], rx_db};
    rx_match = {rx_sh_q[14:0], rx_db} == ~crc_val;
    rx_is_len = fs.pkt_variable && rx_idx_q == 2'h0;
    rx_is_adr = fs.address_filter != 2'h0 && rx_idx_q == {1'b0, fs.pkt_variable};
    rx_rem_new = rx_is_len ? rx_byte : (rx_idx_q == 2'h0 ? fs.payload_length - 8'h01 : rx_rem_q - 8'h01);
    rx_reject = (rx_is_len && (rx_byte >= fs.payload_length || rx_byte == BYTE_RST))
                || (rx_is_adr && !addr_ok(rx_byte, fs));
    if (MODE_IN != MODE_RX) begin
      rx_st_d = RX_SEARCH;
      rx_half_d = 1'b0;
      ready_d = 1'b0;
      crc_ok_d = 1'b0;
    end else begin
      if (rx_st_q == RX_HOLD && fifo_empty) begin
        rx_st_d = RX_SEARCH; // next packet only once the host drained the fifo
        ready_d = 1'b0;
        crc_ok_d = 1'b0;
      end
      if (link_rise) begin
        unique case (rx_st_q)
          RX_SEARCH: begin
            rx_sr_d = {rx_sr_q[30:0], rxd_s_q}; // sync search always runs
            if (fifo_empty && sync_hit(rx_sr_d, SYNC_PATTERN_VALUE_IN, RECEIVER_SETTINGS_IN)) begin
              rx_st_d = RX_PAY; // preamble and sync never reach the fifo
              rx_init = 1'b1;
              rx_bit_d = '0;
              rx_idx_d = '0;
              rx_half_d = 1'b0;
              sync_d = 1'b1;
            end
          end
          RX_PAY, RX_CRC: if (fs.manchester_on && rx_half_q) begin
            rx_half_d = 1'b0; // second chip carries no new information
          end else begin
            rx_half_d = fs.manchester_on;
            rx_take = 1'b1;
          end
          default: ;
        endcase
      end
      if (rx_take) begin
        rx_white_step = 1'b1;
        rx_crc_step = rx_st_q == RX_PAY;
        rx_sh_d = {rx_sh_q[14:0], rx_db};
        rx_bit_d = rx_bit_q + 1'b1;
        if (rx_st_q == RX_PAY && rx_bit_q[2:0] == BYTE_LAST[2:0]) begin
          rx_bit_d = '0;
          if (rx_reject) begin
            rx_flush = 1'b1;
            rx_st_d = RX_SEARCH;
          end else begin
            rx_push = 1'b1; // length and address bytes kept
            rx_rem_d = rx_rem_new;
            rx_idx_d = (rx_idx_q == 2'h3) ? rx_idx_q : rx_idx_q + 2'h1;
            if (rx_rem_new == BYTE_RST) begin
              rx_st_d = fs.crc_on ? RX_CRC : RX_HOLD;
              rx_fin = !fs.crc_on;
            end
          end
        end else if (rx_st_q == RX_CRC && rx_bit_q == CRC_LAST) begin
          rx_fin = 1'b1; // checksum bytes are compared, never stored
        end
      end
      if (rx_fin) begin
        if (fs.crc_on && !rx_match && fs.crc_autoclear) begin
          rx_flush = 1'b1;
          rx_st_d = RX_SEARCH;
          status_d = 1'b0;
        end else begin
          rx_st_d = RX_HOLD;
          ready_d = 1'b1;
          crc_ok_d = fs.crc_on && rx_match;
          status_d = fs.crc_on ? rx_match : status_q;
        end
      end
    end
  end

  crc_white_unit u_crc_white (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .init_in(tx_init | rx_init),
    .crc_step_in(tx_crc_step | rx_crc_step),
    .data_bit_in(tx_crc_step ? tx_sh_q[7] : rx_db),
    .white_step_in(tx_white_step | rx_white_step),
    .crc_out(crc_val),
    .white_bit_out(white_bit)
  );

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= BYTE_RST;
      end
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
      rdata_q <= BYTE_RST;
      tx_st_q <= TX_FILL;
      tx_sh_q <= PREAMBLE_BYTE;
      tx_bit_q <= '0;
      tx_cnt_q <= '0;
      tx_rem_q <= BYTE_RST;
      tx_half_q <= 1'b0;
      tx_out_q <= 1'b0;
      tx_done_q <= 1'b0;
      rx_st_q <= RX_SEARCH;
      rx_sr_q <= '0;
      rx_sh_q <= '0;
      rx_rem_q <= BYTE_RST;
      rx_bit_q <= '0;
      rx_idx_q <= '0;
      rx_half_q <= 1'b0;
      ready_q <= 1'b0;
      crc_ok_q <= 1'b0;
      status_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      count_q <= count_d;
      rdata_q <= rdata_d;
      tx_st_q <= tx_st_d;
      tx_sh_q <= tx_sh_d;
      tx_bit_q <= tx_bit_d;
      tx_cnt_q <= tx_cnt_d;
      tx_rem_q <= tx_rem_d;
      tx_half_q <= tx_half_d;
      tx_out_q <= tx_out_d;
      tx_done_q <= tx_done_d;
      rx_st_q <= rx_st_d;
      rx_sr_q <= rx_sr_d;
      rx_sh_q <= rx_sh_d;
      rx_rem_q <= rx_rem_d;
      rx_bit_q <= rx_bit_d;
      rx_idx_q <= rx_idx_d;
      rx_half_q <= rx_half_d;
      ready_q <= ready_d;
      crc_ok_q <= crc_ok_d;
      status_q <= status_d;
      sync_q <= sync_d;
    end
  end

  assign FIFO_RDATA_OUT = rdata_q;
  assign FIFO_EMPTY_OUT = fifo_empty;
  assign FIFO_FULL_OUT = fifo_full;
  assign FIFO_LEVEL_OUT = 7'(count_q);
  assign TX_DATA_OUT = tx_out_q;
  assign TX_DONE_OUT = tx_done_q;
  assign SYNC_OUT = sync_q;
  assign PAYLOAD_READY_OUT = ready_q;
  assign CRC_OK_OUT = crc_ok_q;
  assign CRC_STATUS_OUT = status_q;
endmodule

/* rtl/radio_packet_pkg.sv */
/*
  types, field layouts and constants shared by the packet handler files.
  assumes nothing beyond a systemverilog compiler.
*/
package radio_packet_pkg;

  // ------------------------------------------------------------
  // modes and states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SLEEP = 2'h0,
    MODE_STBY = 2'h1,
    MODE_RX = 2'h3,
    MODE_TX = 2'h2
  } mode_t;

  typedef enum logic [2:0] {
    TX_FILL = 3'h0,
    TX_PRE = 3'h1,
    TX_SYNC = 3'h3,
    TX_PAY = 3'h2,
    TX_CRC = 3'h6
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_SEARCH = 2'h0,
    RX_PAY = 2'h1,
    RX_CRC = 2'h3,
    RX_HOLD = 2'h2
  } rx_state_t;

  // ------------------------------------------------------------
  // settings carried as packed structs
  // ------------------------------------------------------------
  typedef struct packed {
    logic pkt_variable;
    logic [7:0] payload_length;
    logic [7:0] node_address;
    logic [1:0] address_filter;
    logic crc_on;
    logic crc_autoclear;
    logic manchester_on;
    logic whitening_on;
    logic [1:0] preamble_size;
    logic fifo_standby_access;
    logic [1:0] fifo_size;
    logic [5:0] fifo_threshold;
  } framer_settings_t;

  typedef struct packed {
    logic tx_start_on_first;
  } event_settings_t;

  typedef struct packed {
    logic [1:0] sync_size;
    logic [1:0] sync_tolerance;
  } receiver_settings_t;

  // ------------------------------------------------------------
  // constants
  // ------------------------------------------------------------
  localparam int FIFO_DEPTH_DEF = 64;
  localparam int FIFO_STEP = 16;
  localparam logic [7:0] PREAMBLE_BYTE = 8'hAA;
  localparam logic [7:0] ADDR_BCAST_LOW = 8'h00;
  localparam logic [7:0] ADDR_BCAST_HIGH = 8'hFF;
  localparam logic [1:0] FILT_NODE = 2'h1;
  localparam logic [1:0] FILT_NODE_LOW = 2'h2;
  localparam logic [1:0] FILT_NODE_BOTH = 2'h3;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [8:0] WHITE_INIT = 9'h1FF;
  localparam int WHITE_TAP = 5;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [3:0] CRC_LAST = 4'hF;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // one serial step of the checksum, msb first
  function automatic logic [15:0] crc_next(input logic [15:0] crc, input logic b);
    crc_next = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? CRC_POLY : 16'h0000);
  endfunction

endpackage

/* rtl/crc_white_unit.sv */
/*
  serial checksum generator and 9-bit whitening sequence, shared by
  transmit and receive. assumes the caller steps it once per data bit.
*/
`timescale 1ns/10ps
module crc_white_unit (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic init_in,
  input wire logic crc_step_in,
  input wire logic data_bit_in,
  input wire logic white_step_in,
  output logic [15:0] crc_out,
  output logic white_bit_out
);
  import radio_packet_pkg::*;

  logic [15:0] crc_q, crc_d;
  logic [8:0] lfsr_q, lfsr_d;

  // ------------------------------------------------------------
  // next values
  // ------------------------------------------------------------
  always_comb begin
    crc_d = crc_q;
    lfsr_d = lfsr_q;
    if (init_in) begin
      crc_d = CRC_INIT;
      lfsr_d = WHITE_INIT;
    end else begin
      if (crc_step_in) begin
        crc_d = crc_next(crc_q, data_bit_in);
      end
      if (white_step_in) begin
        lfsr_d = {lfsr_q[0] ^ lfsr_q[WHITE_TAP], lfsr_q[8:1]};
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      crc_q <= CRC_INIT;
      lfsr_q <= WHITE_INIT;
    end else begin
      crc_q <= crc_d;
      lfsr_q <= lfsr_d;
    end
  end

  assign crc_out = crc_q;
  assign white_bit_out = lfsr_q[0];
endmodule

/* bench/radio_packet_handler_checker.sv */
/* port checker for the packet handler.
   assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/10ps
module radio_packet_handler_checker #(
  parameter int DEPTH = 64
) (
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire radio_packet_pkg::mode_t MODE_IN,
  input wire radio_packet_pkg::framer_settings_t FRAMER_SETTINGS_IN,
  input wire logic FIFO_WR_IN,
  input wire logic FIFO_RD_IN,
  input wire logic FIFO_EMPTY_OUT,
  input wire logic FIFO_FULL_OUT,
  input wire logic [6:0] FIFO_LEVEL_OUT,
  input wire logic TX_DATA_OUT,
  input wire logic TX_DONE_OUT,
  input wire logic SYNC_OUT,
  input wire logic PAYLOAD_READY_OUT,
  input wire logic CRC_OK_OUT,
  input wire logic CRC_STATUS_OUT
);
  import radio_packet_pkg::*;
  logic stby;
  // standby only: no link traffic moves the level there
  assign stby = MODE_IN == MODE_STBY && FRAMER_SETTINGS_IN.fifo_standby_access;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_sync_pulse: assert property (SYNC_OUT |=> !SYNC_OUT) else $error("sync too long");
  a_done_leave: assert property (MODE_IN != MODE_TX |=> !TX_DONE_OUT) else $error("done outside tx");
  a_txd_idle: assert property (MODE_IN != MODE_TX |=> !TX_DATA_OUT) else $error("tx data outside tx");
  a_ready_leave: assert property (MODE_IN != MODE_RX |=> !PAYLOAD_READY_OUT) else $error("ready outside rx");
  a_crc_ready: assert property (CRC_OK_OUT |-> PAYLOAD_READY_OUT && CRC_STATUS_OUT) else $error("crc ok alone");
  a_crc_enabled: assert property (CRC_OK_OUT |-> FRAMER_SETTINGS_IN.crc_on) else $error("crc ok while off");
  a_empty_count: assert property (FIFO_EMPTY_OUT == (FIFO_LEVEL_OUT == 7'h00)) else $error("empty flag");
  a_stby_write: assert property (stby && FIFO_WR_IN && !FIFO_RD_IN && !FIFO_FULL_OUT
    |=> FIFO_LEVEL_OUT == $past(FIFO_LEVEL_OUT) + 7'h01) else $error("standby write lost");
  a_stby_read: assert property (stby && FIFO_RD_IN && !FIFO_WR_IN && !FIFO_EMPTY_OUT
    |=> FIFO_LEVEL_OUT == $past(FIFO_LEVEL_OUT) - 7'h01) else $error("standby read lost");
  c_sync: cover property (SYNC_OUT);
  c_done: cover property ($rose(TX_DONE_OUT));
  c_crc_ok: cover property ($rose(CRC_OK_OUT));
endmodule
bind radio_packet_handler radio_packet_handler_checker #(.DEPTH(DEPTH)) u_check (.CLK_IN(CLK_IN),
  .ARST_N_IN(ARST_N_IN), .MODE_IN(MODE_IN), .FRAMER_SETTINGS_IN(FRAMER_SETTINGS_IN), .FIFO_WR_IN(FIFO_WR_IN),
  .FIFO_RD_IN(FIFO_RD_IN), .FIFO_EMPTY_OUT(FIFO_EMPTY_OUT), .FIFO_FULL_OUT(FIFO_FULL_OUT),
  .FIFO_LEVEL_OUT(FIFO_LEVEL_OUT), .TX_DATA_OUT(TX_DATA_OUT), .TX_DONE_OUT(TX_DONE_OUT), .SYNC_OUT(SYNC_OUT),
  .PAYLOAD_READY_OUT(PAYLOAD_READY_OUT), .CRC_OK_OUT(CRC_OK_OUT), .CRC_STATUS_OUT(CRC_STATUS_OUT));

/* bench/link_partner.sv */
/* modem stand-in: records transmitted chips, replays them as rx data.
   assumes the bench gates the link clock with run and picks replay with play. */
`timescale 1ns/10ps
module link_partner (
  input wire logic run_in,
  input wire logic play_in,
  input wire logic tx_in,
  output logic lclk_out,
  output logic rxd_out
);
  logic rec [0:255];
  int n = 0;
  int p = 0;
  initial lclk_out = 1'b0;
  initial rxd_out = 1'b0;
  // ------------------------------------------------------------
  // link clock, still outside frames, odd phase to the system clock
  // ------------------------------------------------------------
  always begin
    wait (run_in);
    #137;
    while (run_in) begin
      #400 lclk_out = ~lclk_out;
    end
    lclk_out = 1'b0;
  end
  always @(posedge lclk_out) begin
    if (!play_in && n < 256) begin
      rec[n] = tx_in;
      n++;
    end
  end
  always @(posedge play_in) p = 0;
  // past the recording the line toggles, so no stale bit looks valid
  always @(negedge lclk_out) begin
    if (play_in && p < n) begin
      rxd_out = rec[p];
      p++;
    end else begin
      rxd_out = ~rxd_out;
    end
  end
endmodule

/* bench/radio_packet_handler_bench.sv */
/* bench for the packet handler: one packet out, replayed back in.
   assumes the partner and checker files are compiled before it. */
`timescale 1ns/10ps
module radio_packet_handler_bench;
  import radio_packet_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  mode_t mode = MODE_STBY;
  framer_settings_t fs;
  event_settings_t es;
  receiver_settings_t rs;
  logic wr = 1'b0;
  logic [7:0] wd = 8'h00;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [6:0] level;
  logic empty, full, lclk, rxd, txd, done, sync, ready, crc_ok, crc_st;
  logic run = 1'b0;
  logic play = 1'b0;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int syncs = 0;
  radio_packet_handler dut (.CLK_IN(clk), .ARST_N_IN(arst_n), .MODE_IN(mode), .FRAMER_SETTINGS_IN(fs),
    .EVENT_SETTINGS_IN(es), .RECEIVER_SETTINGS_IN(rs), .SYNC_PATTERN_VALUE_IN(32'h2DD4_0000), .FIFO_WR_IN(wr),
    .FIFO_WDATA_IN(wd), .FIFO_RD_IN(rd), .FIFO_RDATA_OUT(rdata), .FIFO_EMPTY_OUT(empty), .FIFO_FULL_OUT(full),
    .FIFO_LEVEL_OUT(level), .LINK_CLK_IN(lclk), .RX_DATA_IN(rxd), .TX_DATA_OUT(txd), .TX_DONE_OUT(done),
    .SYNC_OUT(sync), .PAYLOAD_READY_OUT(ready), .CRC_OK_OUT(crc_ok), .CRC_STATUS_OUT(crc_st));
  link_partner p (.run_in(run), .play_in(play), .tx_in(txd), .lclk_out(lclk), .rxd_out(rxd));
  // ------------------------------------------------------------
  // clock, timeout, helpers
  // ------------------------------------------------------------
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (sync === 1'b1) syncs++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  task test_done;
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %0t seen %h want %h", $time, s, e);
    end
  endtask
  task wr_byte(input logic [7:0] b);
    @(posedge clk);
    wr <= 1'b1;
    wd <= b;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_byte(input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_tx;
    int i;
    int j;
    logic hit;
    logic [39:0] w;
    wr_byte(8'h12); // address then message, payload only
    wr_byte(8'h3C);
    @(negedge clk);
    chk(level, 8'h02); // filled in standby, nothing sent yet
    @(posedge clk);
    mode <= MODE_TX;
    run <= 1'b1;
    for (i = 0; i < 3000 && done !== 1'b1; i++) @(posedge clk);
    repeat (20) @(negedge clk);
    chk(done, 1'b1);
    chk(empty, 1'b1);
    @(posedge clk);
    run <= 1'b0;
    mode <= MODE_STBY;
    hit = 1'b0;
    for (i = 0; i + 40 <= p.n; i++) begin
      w = '0;
      for (j = 0; j < 40; j++) w = {w[38:0], p.rec[i + j]};
      if (w === {8'hAA, 16'h2DD4, 8'h12, 8'h3C}) hit = 1'b1;
    end
    chk(hit, 1'b1);
  endtask
  task t_rx(input logic ok);
    int i;
    repeat (5) @(posedge clk);
    mode <= MODE_RX;
    run <= 1'b1;
    play <= 1'b1;
    for (i = 0; i < 2000 && ready !== 1'b1; i++) @(posedge clk);
    @(negedge clk);
    chk(ready, ok);
    chk(crc_ok, ok);
    chk(crc_st, 1'b1);
    chk(level, ok ? 8'h02 : 8'h00);
    @(posedge clk);
    mode <= MODE_STBY;
    run <= 1'b0;
    play <= 1'b0;
    if (ok) begin
      rd_byte(8'h12);
      rd_byte(8'h3C);
    end
    @(negedge clk);
    chk(empty, 1'b1);
  endtask
  initial begin
    fs = '0; // no dc-free coding
    fs.payload_length = 8'h02;
    fs.node_address = 8'h12;
    fs.address_filter = FILT_NODE;
    fs.crc_on = 1'b1;
    fs.crc_autoclear = 1'b1;
    fs.fifo_standby_access = 1'b1;
    fs.fifo_size = 2'h3;
    es.tx_start_on_first = 1'b1;
    rs.sync_size = 2'h1;
    rs.sync_tolerance = 2'h0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk(empty, 1'b1);
    t_tx();
    t_rx(1'b1);
    // a foreign node address fails filter codes 01, 10 and 11
    for (int k = 1; k < 4; k++) begin
      @(posedge clk);
      fs.node_address <= 8'h34;
      fs.address_filter <= k[1:0];
      t_rx(1'b0);
    end
    chk(8'(syncs), 8'h04);
    test_done();
  end
endmodule
